// *** logic/dms_mode_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "dms_cfg.svh"
module dms_mode_ctrl
    import dms_pkg::*;
(
    input wire logic hclk, // Controller clock
    input wire logic hresetn, // Power-on/reset event, low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic [2:0] hsize, // Size, word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Always ready
    output logic hresp, // Always OKAY
    input wire logic power_restored, // Return after brief power loss
    input wire logic option_fitted, // Comm option present
    input wire logic motor_running, // Output active
    input wire logic motor_stop_input, // Stop/enable pin
    input wire logic network_external_select_input, // Net/ext pin
    input wire logic panel_network_select_input, // Panel/net pin
    input wire logic panel_external_select_input, // Panel/ext pin
    input wire logic panel_key, // Panel mode key pulse
    input wire logic start_cmd_in, // Start command from source
    output logic [3:0] op_mode, // One-hot mode
    output logic run_permit, // Start command forwarded
    output logic [5:0] cmd_src // Selected sources
);
    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [5:0] pin_s1_r, pin_s2_r, pin_s1_nxt;
    logic [5:0] pin_prev_r;
    always_comb begin
        pin_s1_nxt = {panel_key, power_restored, motor_stop_input,
            network_external_select_input, panel_network_select_input,
            panel_external_select_input};
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_r <= 6'h00;
            pin_s2_r <= 6'h00;
            pin_prev_r <= 6'h00;
        end else begin
            pin_s1_r <= pin_s1_nxt;
            pin_s2_r <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end
    logic key_s, restore_s, stop_s, ne_s, pn_s, pe_s;
    logic key_pulse, restore_pulse, pn_change;
    assign {key_s, restore_s, stop_s, ne_s, pn_s, pe_s} = pin_s2_r;
    assign key_pulse = key_s & ~pin_prev_r[5];
    assign restore_pulse = restore_s & ~pin_prev_r[4];
    assign pn_change = pn_s ^ pin_prev_r[1];

    // ---------------------------------------------------------------
    // AHB-Lite register slave
    // ---------------------------------------------------------------
    logic [15:0] startup_r, startup_nxt, start_src_r, start_src_nxt;
    logic [15:0] freq_src_r, freq_src_nxt, net_port_r, net_port_nxt;
    logic [15:0] panel_port_r, panel_port_nxt, mode_sel_r, mode_sel_nxt;
    logic [3:0] ctrl_r, ctrl_nxt;
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] wr_addr_r, wr_addr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic sw_req_pulse;
    logic bus_go;
    assign bus_go = hsel & hready & htrans[1];
    // Address phase captured, write lands in data phase, read answered at once
    always_comb begin
        startup_nxt = startup_r;
        start_src_nxt = start_src_r;
        freq_src_nxt = freq_src_r;
        net_port_nxt = net_port_r;
        panel_port_nxt = panel_port_r;
        mode_sel_nxt = mode_sel_r;
        ctrl_nxt = ctrl_r;
        sw_req_pulse = 1'b0;
        wr_pend_nxt = bus_go & hwrite;
        wr_addr_nxt = haddr[7:0];
        hrdata_nxt = hrdata_r;
        if (wr_pend_r) begin
            unique case (wr_addr_r)
                `DMS_OFF_STARTUP: startup_nxt = hwdata[15:0];
                `DMS_OFF_START_SRC: start_src_nxt = hwdata[15:0];
                `DMS_OFF_FREQ_SRC: freq_src_nxt = hwdata[15:0];
                // Port settings take writes in any mode while option connected
                `DMS_OFF_NET_PORT: net_port_nxt = hwdata[15:0]; // R19
                `DMS_OFF_PANEL_PORT: panel_port_nxt = hwdata[15:0]; // R19
                `DMS_OFF_MODE_SEL: mode_sel_nxt = hwdata[15:0];
                `DMS_OFF_CTRL: begin
                    ctrl_nxt = hwdata[3:0];
                    // Go is never stored, so it reads back clear and cannot fire twice
                    ctrl_nxt[`DMS_CTRL_GO_BIT] = 1'b0;
                    sw_req_pulse = hwdata[`DMS_CTRL_GO_BIT];
                end
                default: ;
            endcase
        end
        if (bus_go && !hwrite) begin
            unique case (haddr[7:0])
                `DMS_OFF_STARTUP: hrdata_nxt = {16'h0000, startup_r};
                `DMS_OFF_START_SRC: hrdata_nxt = {16'h0000, start_src_r};
                `DMS_OFF_FREQ_SRC: hrdata_nxt = {16'h0000, freq_src_r};
                `DMS_OFF_NET_PORT: hrdata_nxt = {16'h0000, net_port_r};
                `DMS_OFF_PANEL_PORT: hrdata_nxt = {16'h0000, panel_port_r};
                `DMS_OFF_MODE_SEL: hrdata_nxt = {16'h0000, mode_sel_r};
                `DMS_OFF_CTRL: hrdata_nxt = {28'h0000000, ctrl_r};
                `DMS_OFF_STATUS: hrdata_nxt = {20'h00000, cmd_src, 1'b0, run_permit,
                    op_mode};
                default: hrdata_nxt = 32'h00000000;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            startup_r <= `DMS_RST_STARTUP;
            start_src_r <= `DMS_RST_START_SRC;
            freq_src_r <= `DMS_RST_FREQ_SRC;
            net_port_r <= `DMS_RST_NET_PORT;
            panel_port_r <= `DMS_RST_PANEL_PORT;
            mode_sel_r <= `DMS_RST_MODE_SEL;
            ctrl_r <= 4'h0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end else begin
            startup_r <= startup_nxt;
            start_src_r <= start_src_nxt;
            freq_src_r <= freq_src_nxt;
            net_port_r <= net_port_nxt;
            panel_port_r <= panel_port_nxt;
            mode_sel_r <= mode_sel_nxt;
            ctrl_r <= ctrl_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end
    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ---------------------------------------------------------------
    // Mode evaluation
    // ---------------------------------------------------------------
    logic s_net, s_resume, s_panelnet;
    dms_mode_t op_mode_r, op_mode_nxt, saved_mode_r, saved_mode_nxt;
    assign s_net = (startup_r == 16'h0001) || (startup_r == 16'h0002);
    assign s_panelnet = (startup_r == 16'h000A) || (startup_r == 16'h000C);
    assign s_resume = (startup_r == 16'h0002) || (startup_r == 16'h000C);

    // Startup mode; selection first, then stop input, then startup setting
    function automatic dms_mode_t start_mode(input logic [15:0] sel,
            input logic stop_on);
        dms_mode_t m;
        m = DMS_EXT;
        unique case (sel)
            16'h0001: m = DMS_PANEL; // R2
            16'h0003, 16'h0004: m = DMS_COMB; // R4
            16'h0007: m = (stop_on && s_net) ? DMS_NET : DMS_EXT; // R6 R7 R10
            default: m = (s_net || s_panelnet) ? DMS_NET : DMS_EXT; // R1 R3 R5 R7 R8 R9 R10
        endcase
        return m;
    endfunction

    // Mode requested by pins or software, precedence software, startup 10/12 key or panel/net toggle, net/ext, panel/net, panel/ext
    dms_mode_t req_mode;
    logic req_valid;
    always_comb begin
        req_mode = op_mode_r;
        req_valid = 1'b0;
        if (sw_req_pulse) begin
            req_valid = 1'b1;
            req_mode = (hwdata[1:0] == 2'h1) ? DMS_PANEL :
                (hwdata[1:0] == 2'h2) ? DMS_NET : DMS_EXT;
        end else if (s_panelnet && (key_pulse || pn_change)) begin
            req_valid = 1'b1; // R14
            req_mode = (op_mode_r == DMS_NET) ? DMS_PANEL : DMS_NET; // R14
        end else if (ne_s != pin_prev_r[2]) begin
            req_valid = 1'b1; // R21
            req_mode = ne_s ? DMS_NET : DMS_EXT;
        end else if (pn_change) begin
            req_valid = 1'b1; // R21
            req_mode = pn_s ? DMS_NET : DMS_PANEL;
        end else if (pe_s != pin_prev_r[0]) begin
            req_valid = 1'b1; // R21
            req_mode = pe_s ? DMS_EXT : DMS_PANEL;
        end
    end

    // Whether the current selection lets the requested switch happen
    logic allow;
    always_comb begin
        allow = 1'b0;
        unique case (mode_sel_r)
            16'h0000: allow = s_panelnet ? (req_mode != DMS_EXT) : 1'b1; // R1 R8
            16'h0002: allow = s_panelnet ? 1'b0 : (req_mode != DMS_PANEL); // R3 R9
            16'h0006: allow = 1'b1; // R5
            16'h0007: allow = stop_s; // R6
            default: allow = 1'b0; // R2 R4
        endcase
        if (motor_running && mode_sel_r != 16'h0006)
            allow = 1'b0;
        if (s_net && ((op_mode_r == DMS_PANEL && req_mode == DMS_NET) ||
                (op_mode_r == DMS_NET && req_mode == DMS_PANEL)))
            allow = 1'b0; // R13
    end

    logic init_r, init_nxt, hold_r, hold_nxt, run_r, run_nxt;
    always_comb begin
        op_mode_nxt = op_mode_r;
        saved_mode_nxt = saved_mode_r;
        init_nxt = 1'b0;
        hold_nxt = hold_r;
        run_nxt = start_cmd_in & ~hold_r & ~init_r;
        if (init_r) begin
            op_mode_nxt = start_mode(mode_sel_r, stop_s); // R22
        end else if (restore_pulse) begin
            op_mode_nxt = s_resume ? saved_mode_r : start_mode(mode_sel_r, stop_s); // R20
            if (ctrl_r[`DMS_CTRL_RESTART_BIT])
                op_mode_nxt = saved_mode_r; // R12
            else if (start_cmd_in && (startup_r == 16'h0001 || startup_r == 16'h000A))
                hold_nxt = 1'b1; // R11
            run_nxt = ctrl_r[`DMS_CTRL_RESTART_BIT] & run_r; // R12
        end else if (mode_sel_r == 16'h0007 && !stop_s) begin
            op_mode_nxt = DMS_EXT; // R6
        end else if (req_valid && allow) begin
            op_mode_nxt = req_mode;
        end
        if (!start_cmd_in)
            hold_nxt = 1'b0; // R11
        if (!restore_pulse)
            saved_mode_nxt = op_mode_r;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_mode_r <= DMS_EXT;
            saved_mode_r <= DMS_EXT;
            init_r <= 1'b1;
            hold_r <= 1'b0;
            run_r <= 1'b0;
        end else begin
            op_mode_r <= op_mode_nxt;
            saved_mode_r <= saved_mode_nxt;
            init_r <= init_nxt;
            hold_r <= hold_nxt;
            run_r <= run_nxt;
        end
    end
    assign op_mode = op_mode_r;
    assign run_permit = run_r;

    // ---------------------------------------------------------------
    // Command source selection
    // ---------------------------------------------------------------
    dms_src_t src_r, src_nxt;
    always_comb begin
        src_nxt.start_ext = (start_src_r == 16'h0001); // R15
        src_nxt.freq_ext = (freq_src_r != 16'h0000); // R16
        src_nxt.freq_comm_ok = (freq_src_r != 16'h0001); // R16
        src_nxt.analog2_ok = (freq_src_r == 16'h0001); // R16
        src_nxt.port = DMS_PORT_PANEL;
        if (op_mode_r == DMS_NET) begin
            if (net_port_r == 16'h0000)
                src_nxt.port = DMS_PORT_OPTION; // R17
            else if (net_port_r == 16'h0001)
                src_nxt.port = DMS_PORT_RS485; // R17
            else
                src_nxt.port = option_fitted ? DMS_PORT_OPTION : DMS_PORT_RS485; // R17
        end else begin
            unique case (panel_port_r)
                16'h0001: src_nxt.port = DMS_PORT_RS485; // R18
                16'h0003: src_nxt.port = DMS_PORT_USB; // R18
                default: src_nxt.port = DMS_PORT_PANEL; // R18
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            src_r <= '0;
        else
            src_r <= src_nxt;
    end
    assign cmd_src = src_r;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence stop_low_s;
        !stop_s && mode_sel_r == 16'h0007;
    endsequence
    fixed_panel_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        mode_sel_r == 16'h0001 && op_mode_r == DMS_PANEL && !init_r && !restore_pulse
        |=> op_mode_r == DMS_PANEL)
        else $error("panel mode left while fixed");
    comb_fixed_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
        (mode_sel_r == 16'h0003) && !init_r && !restore_pulse |=> $stable(op_mode_r))
        else $error("combined mode switched");
    stop_forces_a: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        stop_low_s and !init_r and !restore_pulse |=> op_mode_r == DMS_EXT)
        else $error("external not forced");
    start_src_a: assert property (@(posedge hclk) disable iff (!hresetn) // R15
        start_src_r == 16'h0001 |=> src_r.start_ext) else $error("start source wrong");
    freq_src_a: assert property (@(posedge hclk) disable iff (!hresetn) // R16
        freq_src_r == 16'h0002 |=> src_r.freq_ext && !src_r.analog2_ok)
        else $error("freq source wrong");
    net_port_a: assert property (@(posedge hclk) disable iff (!hresetn) // R17
        op_mode_r == DMS_NET && net_port_r == 16'h0001 |=> src_r.port == DMS_PORT_RS485)
        else $error("net port wrong");
    no_direct_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
        s_net && !restore_pulse && !init_r |=> (op_mode_r | $past(op_mode_r)) != 4'h6)
        else $error("direct panel to net");
    init_once_a: assert property (@(posedge hclk) disable iff (!hresetn) // R22
        init_r |=> !init_r ##0 !run_r) else $error("startup evaluated twice");
    drop_start_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
        hold_r && start_cmd_in |=> !run_r) else $error("start not dropped");
endmodule
`default_nettype wire

// *** include/dms_cfg.svh ***
// What this block does
// R1: Startup 0, selection 0: external start, all switches
// R2: Selection 1: panel mode fixed at start
// R3: Selection 2: external start, no switch into panel
// R4: Selection 3 or 4: combined mode, switching refused
// R5: Selection 6: switching allowed while motor runs
// R6: Selection 7: stop input off forces external mode
// R7: Startup 1/2: network start for 0,2,6,7-on
// R8: Startup 10/12, selection 0: panel-network switching only
// R9: Startup 10/12, selection 2: network mode fixed
// R10: Startup 10/12: selection 6 network, 7 external start
// R11: Startup 1/10: start command dropped after restoration
// R12: Restart enabled: resume previous state after restoration
// R13: Startup 1/2: no direct panel-network switch
// R14: Startup 10/12: key or select input toggles panel/network
// R15: Start source 0 communication, 1 external terminals
// R16: Frequency source 0 comm, 1 external, 2 mixed
// R17: Network port: 0 option, 1 RS-485, 9999 auto
// R18: Panel port: 1 RS-485, 2 connector, 3 USB
// R19: Port settings writable while option connected
// R20: Startup 2/12: resume mode held before power loss
// R21: Precedence: selection, stop, net/ext, panel/net, panel/ext, startup
// R22: Startup mode evaluated once per power or reset event
`ifndef DMS_CFG_SVH
`define DMS_CFG_SVH
`define DMS_OFF_STARTUP 8'h00
`define DMS_OFF_START_SRC 8'h04
`define DMS_OFF_FREQ_SRC 8'h08
`define DMS_OFF_NET_PORT 8'h0C
`define DMS_OFF_PANEL_PORT 8'h10
`define DMS_OFF_MODE_SEL 8'h14
`define DMS_OFF_CTRL 8'h18
`define DMS_OFF_STATUS 8'h1C
`define DMS_RST_STARTUP 16'h0000
`define DMS_RST_START_SRC 16'h0000
`define DMS_RST_FREQ_SRC 16'h0000
`define DMS_RST_NET_PORT 16'h270F
`define DMS_RST_PANEL_PORT 16'h0002
`define DMS_RST_MODE_SEL 16'h0000
`define DMS_CTRL_REQ_LSB 0
`define DMS_CTRL_GO_BIT 2
`define DMS_CTRL_RESTART_BIT 3
`endif

// *** include/dms_pkg.sv ***
package dms_pkg;
    // One-hot operation mode codes
    typedef enum logic [3:0] {
        DMS_EXT = 4'h1,
        DMS_PANEL = 4'h2,
        DMS_NET = 4'h4,
        DMS_COMB = 4'h8
    } dms_mode_t;
    // Command port codes
    typedef enum logic [1:0] {
        DMS_PORT_OPTION = 2'h0,
        DMS_PORT_RS485 = 2'h1,
        DMS_PORT_PANEL = 2'h2,
        DMS_PORT_USB = 2'h3
    } dms_port_t;
    // Selected command sources
    typedef struct packed {
        logic start_ext;
        logic freq_ext;
        logic freq_comm_ok;
        logic analog2_ok;
        dms_port_t port;
    } dms_src_t;
endpackage

// *** bench/dms_far_side.sv ***
`timescale 1ns/1ns
`default_nettype none
module dms_far_side (
    input wire logic hclk, // Controller clock
    input wire logic hresetn, // Reset, low
    input wire logic [3:0] pin_set, // Wanted {stop, net_ext, panel_net, panel_ext}
    input wire logic key_push, // Operator presses the panel key
    input wire logic start_set, // Wanted start command level
    output logic motor_stop_input, // Stop/enable terminal
    output logic network_external_select_input, // Net/ext terminal
    output logic panel_network_select_input, // Panel/net terminal
    output logic panel_external_select_input, // Panel/ext terminal
    output logic panel_key, // Panel mode key
    output logic start_cmd_in // Start command from the source
);
    logic [1:0] key_cnt_r;
    // ----------------------------------------
    // Terminals and panel key
    // ----------------------------------------
    // Key is held three edges so the two-stage synchroniser cannot miss it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            motor_stop_input <= 1'b0;
            network_external_select_input <= 1'b0;
            panel_network_select_input <= 1'b0;
            panel_external_select_input <= 1'b0;
            start_cmd_in <= 1'b0;
            key_cnt_r <= 2'h0;
        end else begin
            motor_stop_input <= pin_set[3];
            network_external_select_input <= pin_set[2];
            panel_network_select_input <= pin_set[1];
            panel_external_select_input <= pin_set[0];
            start_cmd_in <= start_set;
            if (key_push) begin
                key_cnt_r <= 2'h3;
            end else if (key_cnt_r != 2'h0) begin
                key_cnt_r <= key_cnt_r - 2'h1;
            end
        end
    end
    assign panel_key = (key_cnt_r != 2'h0);
endmodule
`default_nettype wire

// *** bench/drive_mode_source_select_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "dms_cfg.svh"
module drive_mode_source_select_tb import dms_pkg::*; ();
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic power_restored = 1'b0;
    logic option_fitted = 1'b1;
    logic motor_running = 1'b0;
    logic key_push = 1'b0;
    logic start_set = 1'b0;
    logic [3:0] pin_set = 4'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, run_permit;
    logic [3:0] op_mode;
    logic [5:0] cmd_src;
    wire logic stop_w, netext_w, panelnet_w, panelext_w, key_w, start_w;
    int err_count = 0;
    int checks = 0;
    logic [31:0] start_tbl [16] = '{32'h0000_0001, 32'h0001_0002, 32'h0002_0001,
        32'h0003_0008, 32'h0004_0008, 32'h0006_0001, 32'h0007_1001, 32'h0100_0004,
        32'h0102_0004, 32'h0106_0004, 32'h0107_1004, 32'h0107_0001, 32'h0A00_0004,
        32'h0A02_0004, 32'h0A06_0004, 32'h0A07_1001};
    logic [31:0] sw_tbl [13] = '{32'h0000_0012, 32'h0000_0024, 32'h0001_0002,
        32'h0002_0011, 32'h0002_0024, 32'h0003_0008, 32'h0006_0112, 32'h0000_0111,
        32'h0007_0011, 32'h0007_1012, 32'h0100_0014, 32'h0A00_0004, 32'h0A02_0014};

    always #2 hclk = ~hclk;

    dms_far_side far (.hclk(hclk), .hresetn(hresetn), .pin_set(pin_set), .key_push(key_push),
        .start_set(start_set), .motor_stop_input(stop_w), .network_external_select_input(netext_w),
        .panel_network_select_input(panelnet_w), .panel_external_select_input(panelext_w),
        .panel_key(key_w), .start_cmd_in(start_w));

    dms_mode_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .power_restored(power_restored),
        .option_fitted(option_fitted), .motor_running(motor_running), .motor_stop_input(stop_w),
        .network_external_select_input(netext_w), .panel_network_select_input(panelnet_w),
        .panel_external_select_input(panelext_w), .panel_key(key_w), .start_cmd_in(start_w),
        .op_mode(op_mode), .run_permit(run_permit), .cmd_src(cmd_src));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic close_out();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Single word transfer; waits on hready rather than assuming zero wait states
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge hclk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    // Settings, then a brief power loss so the start mode is taken again, or the held mode resumed for startup 2/12 or restart
    task automatic restore(input logic [31:0] c);
        wr(`DMS_OFF_STARTUP, {24'h0, c[31:24]});
        wr(`DMS_OFF_MODE_SEL, {24'h0, c[23:16]});
        pin_set[3] <= c[12];
        motor_running <= c[8];
        wait_cyc(6);
        power_restored <= 1'b1;
        wait_cyc(3);
        power_restored <= 1'b0;
        wait_cyc(8);
    endtask

    task automatic mode_chk(input logic [3:0] e);
        wait_cyc(6);
        chk({28'h0, op_mode}, {28'h0, e});
    endtask

    task automatic port_chk(input logic [7:0] a, input logic [15:0] v, input logic fit,
        input dms_port_t e);
        option_fitted <= fit;
        wr(a, {16'h0, v});
        wait_cyc(4);
        chk({30'h0, cmd_src[1:0]}, {30'h0, e});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        chk({28'h0, op_mode}, {28'h0, DMS_EXT});
        rd_chk(`DMS_OFF_STARTUP, {16'h0, `DMS_RST_STARTUP});
        rd_chk(`DMS_OFF_START_SRC, {16'h0, `DMS_RST_START_SRC});
        rd_chk(`DMS_OFF_FREQ_SRC, {16'h0, `DMS_RST_FREQ_SRC});
        rd_chk(`DMS_OFF_NET_PORT, {16'h0, `DMS_RST_NET_PORT});
        rd_chk(`DMS_OFF_PANEL_PORT, {16'h0, `DMS_RST_PANEL_PORT});
        rd_chk(`DMS_OFF_STATUS, 32'h0000_0281);
        chk({31'h0, hresp}, 32'h0);
        wr(`DMS_OFF_NET_PORT, 32'h0000_0001);
        rd_chk(`DMS_OFF_NET_PORT, 32'h0000_0001);
        wr(`DMS_OFF_NET_PORT, {16'h0, `DMS_RST_NET_PORT});
        // Unmapped place swallows writes and reads zero
        wr(8'h20, 32'h0000_FFFF);
        rd_chk(8'h20, 32'h0);
    endtask

    task automatic t_start();
        for (int i = 0; i < 16; i++) begin
            restore(start_tbl[i]);
            chk({28'h0, op_mode}, {28'h0, start_tbl[i][3:0]});
        end
    endtask

    // Each case starts fresh, then one software request which may be refused
    task automatic t_switch();
        for (int i = 0; i < 13; i++) begin
            restore(sw_tbl[i]);
            wr(`DMS_OFF_CTRL, {28'h0, 2'b01, sw_tbl[i][5:4]});
            mode_chk(sw_tbl[i][3:0]);
        end
        motor_running <= 1'b0;
    endtask

    task automatic t_pins();
        restore(32'h0000_0000);
        pin_set[2] <= 1'b1;
        mode_chk(DMS_NET);
        pin_set[2] <= 1'b0;
        mode_chk(DMS_EXT);
        restore(32'h0A00_0000);
        for (int i = 0; i < 2; i++) begin
            key_push <= 1'b1;
            wait_cyc(1);
            key_push <= 1'b0;
            mode_chk(i == 0 ? DMS_PANEL : DMS_NET);
        end
    endtask

    task automatic t_power();
        start_set <= 1'b1;
        restore(32'h0100_0000);
        chk({31'h0, run_permit}, 32'h0);
        start_set <= 1'b0;
        wait_cyc(4);
        start_set <= 1'b1;
        wait_cyc(4);
        chk({31'h0, run_permit}, 32'h1);
        start_set <= 1'b0;
        restore(32'h0200_0000);
        wr(`DMS_OFF_CTRL, 32'h0000_0004);
        restore(32'h0200_0000);
        chk({28'h0, op_mode}, {28'h0, DMS_EXT});
        restore(32'h0000_0000);
        wr(`DMS_OFF_CTRL, 32'h0000_000D);
        restore(32'h0000_0000);
        chk({28'h0, op_mode}, {28'h0, DMS_PANEL});
        wr(`DMS_OFF_CTRL, 32'h0000_0000);
    endtask

    task automatic t_src();
        restore(32'h0A02_0000);
        wr(`DMS_OFF_START_SRC, 32'h1);
        wr(`DMS_OFF_FREQ_SRC, 32'h1);
        wait_cyc(4);
        chk({30'h0, cmd_src[5:4]}, 32'h3);
        wr(`DMS_OFF_START_SRC, 32'h0);
        wr(`DMS_OFF_FREQ_SRC, 32'h2);
        wait_cyc(4);
        chk({28'h0, cmd_src[5:2]}, 32'h6);
        wr(`DMS_OFF_FREQ_SRC, 32'h0);
        wait_cyc(4);
        chk({31'h0, cmd_src[4]}, 32'h0);
        port_chk(`DMS_OFF_NET_PORT, 16'h0000, 1'b1, DMS_PORT_OPTION);
        port_chk(`DMS_OFF_NET_PORT, 16'h0001, 1'b1, DMS_PORT_RS485);
        port_chk(`DMS_OFF_NET_PORT, 16'h270F, 1'b1, DMS_PORT_OPTION);
        port_chk(`DMS_OFF_NET_PORT, 16'h270F, 1'b0, DMS_PORT_RS485);
        option_fitted <= 1'b1;
        restore(32'h0001_0000);
        port_chk(`DMS_OFF_PANEL_PORT, 16'h0001, 1'b1, DMS_PORT_RS485);
        port_chk(`DMS_OFF_PANEL_PORT, 16'h0002, 1'b1, DMS_PORT_PANEL);
        port_chk(`DMS_OFF_PANEL_PORT, 16'h0003, 1'b1, DMS_PORT_USB);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        wait_cyc(5);
        hresetn <= 1'b1;
        wait_cyc(1);
        t_regs();
        t_start();
        t_switch();
        t_pins();
        t_power();
        t_src();
        close_out();
    end

    // Whole run is about 1150 cycles; this leaves ample margin
    initial begin
        #100000;
        err_count++;
        close_out();
    end
endmodule
`default_nettype wire
